/* sbgl_mdc_edge.sv */
// detects management clock rising edges and captures the data bit
`timescale 1ns/1ps
`default_nettype none
module sbgl_mdc_edge
  import sbgl_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   resetn_in,
  input  wire logic   clk_en_in,
  input  wire logic   mdc_in,
  input  wire logic   mdio_in,
  sbgl_mdc_if.src     ev
);

  typedef struct packed {
    logic mdc;
    logic rise;
    logic bit_val;
  } sbgl_edge_st_t;

  sbgl_edge_st_t r_q;
  sbgl_edge_st_t r_d;

  always_comb begin
    r_d      = r_q;
    r_d.mdc  = mdc_in;
    r_d.rise = mdc_in & ~r_q.mdc;
    if (mdc_in && !r_q.mdc) begin
      r_d.bit_val = mdio_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      r_q <= '0;
    end else if (clk_en_in) begin
      r_q <= r_d;
    end
  end

  // pulse is one cycle wide and gated by the clock enable, so a frozen clock enable cannot stretch it
  assign ev.rise    = r_q.rise & clk_en_in;
  assign ev.bit_val = r_q.bit_val;

endmodule : sbgl_mdc_edge
`default_nettype wire

/* sbgl_mdc_if.sv */
// management clock edge events passed from the sampler to the bank
`timescale 1ns/1ps
`default_nettype none
interface sbgl_mdc_if;
  logic rise;
  logic bit_val;
  modport src (output rise, output bit_val);
  modport snk (input rise, input bit_val);
endinterface : sbgl_mdc_if
`default_nettype wire

/* sbgl_mgmt_model.sv */
// station management model: makes mdc and drives or samples mdio frames
`timescale 1ns/1ps
`default_nettype none
module sbgl_mgmt_model
  import sbgl_pkg::*;
#(
  parameter int HALF = 10
)(
  input  wire logic clk_in,
  input  wire logic mdio_line_in,
  output var  logic mdc_out,
  output var  logic mdio_drv_out,
  output var  logic mdio_oe_out
);
  initial begin
    mdc_out      = 1'b0;
    mdio_drv_out = 1'b1;
    mdio_oe_out  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one mdc period: change data while mdc low, sample at the fall
  // half period of 10 clocks keeps mdc at 10 MHz, the fastest allowed
  task automatic cyc(input logic drv, input logic b, output logic s);
    mdio_oe_out  <= drv;
    mdio_drv_out <= b;
    repeat (HALF) @(posedge clk_in);
    mdc_out <= 1'b1;
    repeat (HALF) @(posedge clk_in);
    s = mdio_line_in;
    mdc_out <= 1'b0;
  endtask : cyc

  // whole frame; mdc stands still and the line is released afterwards
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] regad, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ta);
    logic [13:0] hdr;
    logic        rdop;
    logic        s;
    hdr  = {2'b01, op, phy, regad};
    rdop = (op == OP_READ);
    rd   = 16'h0000;
    for (int i = 0; i < 32; i++)
      cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      cyc(1'b1, hdr[i], s);
    cyc(~rdop, 1'b1, s);
    cyc(~rdop, 1'b0, s);
    ta = s;
    for (int i = 15; i >= 0; i--) begin
      cyc(~rdop, wd[i], s);
      rd[i] = s;
    end
    if (rdop)
      cyc(1'b0, 1'b1, s);
    mdio_oe_out <= 1'b0;
  endtask : frame
endmodule : sbgl_mgmt_model
`default_nettype wire

/* sbgl_pkg.sv */
// shared constants and types for the global and lane a setup bank
`default_nettype none
package sbgl_pkg;

  localparam int unsigned DATA_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // management frame
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_GLOBAL = 5'h10;
  localparam logic [4:0] REG_LANE_A = 5'h11;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [5:0] PRE_MIN    = 6'h20;
  localparam logic [3:0] HDR_LAST   = 4'hb;
  localparam logic [3:0] DATA_LAST  = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // global_setup fields
  localparam int unsigned G_UPPER_PAIR_PORT_PICK = 12;
  localparam int unsigned G_LOWER_PAIR_PORT_PICK = 11;
  localparam int unsigned G_PORT_PICK_MODE       = 10;
  localparam int unsigned G_FANOUT_MODE          = 9;
  localparam int unsigned G_SIGNAL_LOSS_REPORT   = 8;
  localparam int unsigned G_CFG_CODE_HI          = 7;
  localparam int unsigned G_CFG_CODE_LO          = 6;
  localparam int unsigned G_EMPHASIS_LEVEL_HI    = 5;
  localparam int unsigned G_EMPHASIS_LEVEL_LO    = 4;
  localparam int unsigned G_PSEUDO_RANDOM_TEST   = 2;
  localparam int unsigned G_COMMA_ALIGN          = 1;
  localparam logic [15:0] GLOBAL_RST   = 16'h0102;
  localparam logic [15:0] GLOBAL_WMASK = 16'h1ff6;

  ////////////////////////////////////////////////////////////////////////////
  // lane_a_setup fields
  localparam int unsigned L_SIGNAL_LOSS_REPORT = 8;
  localparam int unsigned L_CFG_CODE_HI        = 7;
  localparam int unsigned L_CFG_CODE_LO        = 6;
  localparam int unsigned L_EMPHASIS_LEVEL_HI  = 5;
  localparam int unsigned L_EMPHASIS_LEVEL_LO  = 4;
  localparam int unsigned L_LOOPBACK           = 3;
  localparam int unsigned L_PSEUDO_RANDOM_TEST = 2;
  localparam int unsigned L_COMMA_ALIGN        = 1;
  localparam int unsigned L_POWER_DOWN         = 0;
  localparam logic [15:0] LANE_A_RST   = 16'h0132;
  localparam logic [15:0] LANE_A_WMASK = 16'h01ff;

  ////////////////////////////////////////////////////////////////////////////
  // control register, only the bits this bank combines with
  localparam int unsigned C_LOOPBACK   = 14;
  localparam int unsigned C_POWER_DOWN = 11;
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] CTRL_WMASK   = 16'h4800;
  localparam logic [15:0] CTRL_FIXED   = 16'h2140;

  typedef enum logic [2:0] {
    ST_PRE,
    ST_START,
    ST_HDR,
    ST_TA,
    ST_DATA,
    ST_REL
  } sbgl_fsm_t;

endpackage : sbgl_pkg
`default_nettype wire

/* sbgl_rd_mux.sv */
// read data selection for the management registers
`timescale 1ns/1ps
`default_nettype none
module sbgl_rd_mux
  import sbgl_pkg::*;
(
  input  wire logic [4:0]        reg_addr_in,
  input  wire logic [DATA_W-1:0] glb_in,
  input  wire logic [DATA_W-1:0] lna_in,
  input  wire logic [DATA_W-1:0] ctl_in,
  output var  logic [DATA_W-1:0] rd_data_out
);

  always_comb begin
    case (reg_addr_in)
      REG_CTRL:   rd_data_out = (ctl_in & CTRL_WMASK) | CTRL_FIXED;
      REG_GLOBAL: rd_data_out = glb_in & GLOBAL_WMASK;
      REG_LANE_A: rd_data_out = lna_in & LANE_A_WMASK;
      // registers outside this bank answer with zero
      default:    rd_data_out = '0;
    endcase
  end

endmodule : sbgl_rd_mux
`default_nettype wire

/* sbgl_top.sv */
// management register bank: global setup and lane a setup over mdio
//
// Summary of operation
// - port-choice mode: global bit 12 picks lane C when set, D when clear
// - port-choice mode: global bit 11 picks lane B when set, A when clear
// - global bit 10 enables port-choice mode; resets zero, reads back
// - global bit 9 enables fan-out mode; resets zero, reads back
// - global bit 8 allows signal-loss reporting, not combined with lane A bit 8; resets one
// - global bits 7:6 hold the operating role code; reset zero
// - global bits 5:4 hold transmit emphasis level; reset zero
// - global bit 2 enables pseudo-random test on all lanes; reset zero
// - global bit 1 enables comma alignment on all lanes; resets one
// - global bits 15:13, 3 and 0 are reserved and read-only
// - lane A bit 8 allows lane A signal-loss reporting; resets one
// - lane A bits 7:6 hold lane A role code; reset zero
// - lane A bits 5:4 hold lane A emphasis level; both reset one
// - lane A bit 3 loopback, effective value ORed with control bit 14
// - lane A bit 2 pseudo-random test, ORed with global bit 2
// - lane A bit 1 comma alignment, resets one, ORed with global bit 1
// - lane A bit 0 power down, ORed with control bit 11
// - control bit 14 enables loopback on all lanes; resets zero
// - control bit 11 power down is ORed with the inverted enable pin
// - bits sampled and launched on management clock rise, up to 10 MHz
`timescale 1ns/1ps
`default_nettype none
module sbgl_top
  import sbgl_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       clk_en_in,
  input  wire logic       mdc_in,
  input  wire logic       mdio_in,
  input  wire logic [4:0] phy_addr_in,
  input  wire logic       dev_enable_in,
  output var  logic       mdio_drv_out,
  output var  logic       mdio_oe_out,
  output var  logic       upper_pair_port_pick_out,
  output var  logic       lower_pair_port_pick_out,
  output var  logic       port_pick_mode_out,
  output var  logic       fanout_mode_out,
  output var  logic       signal_loss_report_out,
  output var  logic [1:0] cfg_code_out,
  output var  logic [1:0] emphasis_level_out,
  output var  logic       pseudo_random_test_out,
  output var  logic       comma_align_out,
  output var  logic       lane_a_signal_loss_report_out,
  output var  logic [1:0] lane_a_cfg_code_out,
  output var  logic [1:0] lane_a_emphasis_level_out,
  output var  logic       lane_a_loopback_out,
  output var  logic       lane_a_pseudo_random_test_out,
  output var  logic       lane_a_comma_align_out,
  output var  logic       lane_a_power_down_out,
  output var  logic       loopback_all_out,
  output var  logic       power_down_all_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    sbgl_fsm_t         fsm;
    logic [5:0]        pre_cnt;
    logic [3:0]        cnt;
    logic [DATA_W-1:0] sh;
    logic              is_rd;
    logic [4:0]        reg_addr;
    logic [DATA_W-1:0] glb;
    logic [DATA_W-1:0] lna;
    logic [DATA_W-1:0] ctl;
    logic              mdio_drv;
    logic              mdio_oe;
    logic              eff_loop;
    logic              eff_prt;
    logic              eff_comma;
    logic              eff_pdn;
    logic              pdn_all;
  } sbgl_st_t;

  localparam sbgl_st_t RST_ST = '{
    fsm:       ST_PRE,
    pre_cnt:   6'h00,
    cnt:       4'h0,
    sh:        16'h0000,
    is_rd:     1'b0,
    reg_addr:  5'h00,
    glb:       GLOBAL_RST,
    lna:       LANE_A_RST,
    ctl:       CTRL_RST,
    mdio_drv:  1'b0,
    mdio_oe:   1'b0,
    eff_loop:  1'b0,
    eff_prt:   1'b0,
    eff_comma: 1'b1,
    eff_pdn:   1'b0,
    pdn_all:   1'b0
  };

  sbgl_st_t          r_q;
  sbgl_st_t          r_d;
  logic              wr_fire;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] wdata;
  logic [1:0]        hdr_op;

  sbgl_mdc_if ev ();

  sbgl_mdc_edge u_edge (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clk_en_in (clk_en_in),
    .mdc_in    (mdc_in),
    .mdio_in   (mdio_in),
    .ev        (ev)
  );

  sbgl_rd_mux u_rd_mux (
    .reg_addr_in (r_q.reg_addr),
    .glb_in      (r_q.glb),
    .lna_in      (r_q.lna),
    .ctl_in      (r_q.ctl),
    .rd_data_out (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame engine and register writes

  // next shift value from registered state only, so no loop through r_d
  assign wdata  = {r_q.sh[DATA_W-2:0], ev.bit_val};
  assign hdr_op = wdata[11:10];

  always_comb begin
    r_d     = r_q;
    wr_fire = 1'b0;
    if (ev.rise) begin
      unique case (r_q.fsm)
        ST_PRE: begin
          if (ev.bit_val) begin
            if (r_q.pre_cnt != PRE_MIN) begin
              r_d.pre_cnt = r_q.pre_cnt + 6'h01;
            end
          end else begin
            r_d.pre_cnt = 6'h00;
            if (r_q.pre_cnt == PRE_MIN) begin
              r_d.fsm = ST_START;
            end
          end
        end
        ST_START: begin
          r_d.cnt = 4'h0;
          r_d.fsm = ev.bit_val ? ST_HDR : ST_PRE;
        end
        ST_HDR: begin
          r_d.sh  = {r_q.sh[DATA_W-2:0], ev.bit_val};
          r_d.cnt = r_q.cnt + 4'h1;
          if (r_q.cnt == HDR_LAST) begin
            r_d.cnt = 4'h0;
            // foreign address or bad opcode: idle until the next preamble
            if ((hdr_op == OP_WRITE || hdr_op == OP_READ)
                && wdata[9:5] == phy_addr_in) begin
              r_d.fsm      = ST_TA;
              r_d.is_rd    = (hdr_op == OP_READ);
              r_d.reg_addr = wdata[4:0];
            end else begin
              r_d.fsm = ST_PRE;
            end
          end
        end
        ST_TA: begin
          r_d.cnt = r_q.cnt + 4'h1;
          if (r_q.cnt[0]) begin
            r_d.cnt = 4'h0;
            r_d.fsm = ST_DATA;
            if (r_q.is_rd) begin
              r_d.mdio_oe  = 1'b1;
              r_d.mdio_drv = 1'b0;
              r_d.sh       = rd_data;
            end
          end
        end
        ST_DATA: begin
          r_d.cnt = r_q.cnt + 4'h1;
          if (r_q.is_rd) begin
            r_d.mdio_drv = r_q.sh[DATA_W-1];
            r_d.sh       = {r_q.sh[DATA_W-2:0], 1'b0};
          end else begin
            r_d.sh = {r_q.sh[DATA_W-2:0], ev.bit_val};
          end
          if (r_q.cnt == DATA_LAST) begin
            r_d.fsm = r_q.is_rd ? ST_REL : ST_PRE;
            wr_fire = !r_q.is_rd;
          end
        end
        ST_REL: begin
          // hold the last bit a full management clock period, until the next mdc rise, before letting go of the line
          r_d.mdio_oe  = 1'b0;
          r_d.mdio_drv = 1'b0;
          r_d.fsm      = ST_PRE;
        end
      endcase
    end

    if (wr_fire) begin
      if (r_q.reg_addr == REG_GLOBAL) begin
        r_d.glb = wdata & GLOBAL_WMASK;
      end
      if (r_q.reg_addr == REG_LANE_A) begin
        r_d.lna = wdata & LANE_A_WMASK;
      end
      if (r_q.reg_addr == REG_CTRL) begin
        r_d.ctl = wdata & CTRL_WMASK;
      end
    end

    // effective lane a controls track the next register values
    r_d.eff_loop  = r_d.lna[L_LOOPBACK] | r_d.ctl[C_LOOPBACK];
    r_d.eff_prt   = r_d.lna[L_PSEUDO_RANDOM_TEST]
                  | r_d.glb[G_PSEUDO_RANDOM_TEST];
    r_d.eff_comma = r_d.lna[L_COMMA_ALIGN]
                  | r_d.glb[G_COMMA_ALIGN];
    r_d.pdn_all   = r_d.ctl[C_POWER_DOWN] | ~dev_enable_in;
    r_d.eff_pdn   = r_d.lna[L_POWER_DOWN] | r_d.pdn_all;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      r_q <= RST_ST;
    end else if (clk_en_in) begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign mdio_drv_out             = r_q.mdio_drv;
  assign mdio_oe_out              = r_q.mdio_oe;
  assign upper_pair_port_pick_out = r_q.glb[G_UPPER_PAIR_PORT_PICK];
  assign lower_pair_port_pick_out = r_q.glb[G_LOWER_PAIR_PORT_PICK];
  assign port_pick_mode_out       = r_q.glb[G_PORT_PICK_MODE];
  assign fanout_mode_out          = r_q.glb[G_FANOUT_MODE];
  assign signal_loss_report_out   = r_q.glb[G_SIGNAL_LOSS_REPORT];
  assign cfg_code_out             = {r_q.glb[G_CFG_CODE_HI],
                                     r_q.glb[G_CFG_CODE_LO]};
  assign emphasis_level_out       = {r_q.glb[G_EMPHASIS_LEVEL_HI],
                                     r_q.glb[G_EMPHASIS_LEVEL_LO]};
  assign pseudo_random_test_out   = r_q.glb[G_PSEUDO_RANDOM_TEST];
  assign comma_align_out          = r_q.glb[G_COMMA_ALIGN];
  assign lane_a_signal_loss_report_out =
    r_q.lna[L_SIGNAL_LOSS_REPORT];
  assign lane_a_cfg_code_out      = {r_q.lna[L_CFG_CODE_HI],
                                     r_q.lna[L_CFG_CODE_LO]};
  assign lane_a_emphasis_level_out = {r_q.lna[L_EMPHASIS_LEVEL_HI],
                                      r_q.lna[L_EMPHASIS_LEVEL_LO]};
  assign lane_a_loopback_out           = r_q.eff_loop;
  assign lane_a_pseudo_random_test_out = r_q.eff_prt;
  assign lane_a_comma_align_out        = r_q.eff_comma;
  assign lane_a_power_down_out         = r_q.eff_pdn;
  assign loopback_all_out              = r_q.ctl[C_LOOPBACK];
  assign power_down_all_out            = r_q.pdn_all;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in);
  endclocking

  default disable iff (!resetn_in);

  glb_write_a : assert property (
    (wr_fire && clk_en_in && r_q.reg_addr == REG_GLOBAL)
      |=> (r_q.glb == ($past(wdata) & GLOBAL_WMASK))
         && (port_pick_mode_out == $past(wdata[G_PORT_PICK_MODE])))
    else $error("global setup write not taken");

  lane_write_a : assert property (
    (wr_fire && clk_en_in && r_q.reg_addr == REG_LANE_A)
      |=> lane_a_cfg_code_out == $past(wdata[L_CFG_CODE_HI:L_CFG_CODE_LO]))
    else $error("lane a setup write not taken");

  rsvd_zero_a : assert property (
    ((r_q.glb & ~GLOBAL_WMASK) == 16'h0000)
      && ((r_q.lna & ~LANE_A_WMASK) == 16'h0000))
    else $error("reserved bit became set");

  reset_value_a : assert property (
    disable iff (1'b0)
    !resetn_in |=> (r_q.glb == GLOBAL_RST) && (r_q.lna == LANE_A_RST)
                   && lane_a_emphasis_level_out == 2'h3
                   && !port_pick_mode_out && signal_loss_report_out)
    else $error("wrong value after reset");

  lane_loop_a : assert property (
    lane_a_loopback_out == (r_q.lna[L_LOOPBACK] | loopback_all_out))
    else $error("lane a loopback not combined");

  lane_prt_a : assert property (
    lane_a_pseudo_random_test_out
      == (r_q.lna[L_PSEUDO_RANDOM_TEST] | pseudo_random_test_out))
    else $error("lane a pseudo-random test not combined");

  lane_comma_a : assert property (
    lane_a_comma_align_out == (r_q.lna[L_COMMA_ALIGN] | comma_align_out))
    else $error("lane a comma alignment not combined");

  power_down_a : assert property (
    ($past(resetn_in) && $past(clk_en_in))
      |-> (lane_a_power_down_out == (r_q.lna[L_POWER_DOWN]
           | r_q.ctl[C_POWER_DOWN] | !$past(dev_enable_in)))
         && (power_down_all_out
           == (r_q.ctl[C_POWER_DOWN] | !$past(dev_enable_in))))
    else $error("power down not combined with enable pin");

  turnaround_a : assert property (
    (ev.rise && r_q.fsm == ST_TA && r_q.cnt[0] && r_q.is_rd)
      |=> mdio_oe_out && !mdio_drv_out)
    else $error("turnaround zero not driven");

  drive_hold_a : assert property (
    $rose(mdio_oe_out) |-> mdio_oe_out [*8])
    else $error("read drive released early");

  launch_edge_a : assert property (
    ($changed(mdio_drv_out) || $changed(mdio_oe_out)) |-> $past(ev.rise))
    else $error("data line changed away from a clock rise");

  cov_glb_write : cover property (
    wr_fire && clk_en_in && r_q.reg_addr == REG_GLOBAL);

  cov_lane_read : cover property (
    ev.rise && r_q.fsm == ST_REL && r_q.reg_addr == REG_LANE_A);

  cov_pick_mode : cover property ($rose(port_pick_mode_out));

  cov_ctrl_loop : cover property ($rose(loopback_all_out));

endmodule : sbgl_top
`default_nettype wire

/* sbgl_top_tb.sv */
// self-checking bench for the global and lane a setup bank
`timescale 1ns/1ps
`default_nettype none
module sbgl_top_tb;
  import sbgl_pkg::*;
  localparam logic [4:0] PHY = 5'h05;

  logic clk_in, resetn_in, clk_en_in, dev_enable_in;
  logic [4:0] phy_addr_in;
  wire logic mdc_in, mdio_in, m_drv, m_oe;
  logic mdio_drv_out, mdio_oe_out, upper_pair_port_pick_out;
  logic lower_pair_port_pick_out, port_pick_mode_out, fanout_mode_out;
  logic signal_loss_report_out, pseudo_random_test_out, comma_align_out;
  logic [1:0] cfg_code_out, emphasis_level_out, lane_a_cfg_code_out;
  logic [1:0] lane_a_emphasis_level_out;
  logic lane_a_signal_loss_report_out, lane_a_loopback_out;
  logic lane_a_pseudo_random_test_out, lane_a_comma_align_out;
  logic lane_a_power_down_out, loopback_all_out, power_down_all_out;
  logic [15:0] g_exp, l_exp, c_exp, r;
  logic        t;
  int          err_count, checks_done;

  // pulled-up line: released by both parties it reads one
  assign mdio_in = mdio_oe_out ? mdio_drv_out : (m_oe ? m_drv : 1'b1);

  sbgl_top DUT (.clk_in, .resetn_in, .clk_en_in, .mdc_in, .mdio_in,
    .phy_addr_in, .dev_enable_in, .mdio_drv_out, .mdio_oe_out,
    .upper_pair_port_pick_out, .lower_pair_port_pick_out,
    .port_pick_mode_out, .fanout_mode_out, .signal_loss_report_out,
    .cfg_code_out, .emphasis_level_out, .pseudo_random_test_out,
    .comma_align_out, .lane_a_signal_loss_report_out,
    .lane_a_cfg_code_out, .lane_a_emphasis_level_out, .lane_a_loopback_out,
    .lane_a_pseudo_random_test_out, .lane_a_comma_align_out,
    .lane_a_power_down_out, .loopback_all_out, .power_down_all_out);

  sbgl_mgmt_model #(.HALF(10)) mgr (.clk_in, .mdio_line_in(mdio_in),
    .mdc_out(mdc_in), .mdio_drv_out(m_drv), .mdio_oe_out(m_oe));

  always #2.5 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    mgr.frame(OP_WRITE, PHY, a, d, r, t);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    mgr.frame(OP_READ, PHY, a, 16'h0000, r, t);
    check({15'h0, t}, 16'h0000);
    check({15'h0, mdio_oe_out}, 16'h0000);
    check(r, exp);
  endtask : rd

  // outputs packed like the registers; lane bits 3:0 carry the ors
  task automatic chk_all();
    logic [15:0] lx;
    repeat (2) @(posedge clk_in);
    lx = l_exp | {12'h0, c_exp[14], g_exp[2], g_exp[1],
                  c_exp[11] | ~dev_enable_in};
    check({3'h0, upper_pair_port_pick_out, lower_pair_port_pick_out,
           port_pick_mode_out, fanout_mode_out, signal_loss_report_out,
           cfg_code_out, emphasis_level_out, 1'b0, pseudo_random_test_out,
           comma_align_out, 1'b0},
          g_exp);
    check({7'h0, lane_a_signal_loss_report_out, lane_a_cfg_code_out,
           lane_a_emphasis_level_out, lane_a_loopback_out,
           lane_a_pseudo_random_test_out, lane_a_comma_align_out,
           lane_a_power_down_out},
          lx);
    check({14'h0, loopback_all_out, power_down_all_out},
          {14'h0, c_exp[14], c_exp[11] | ~dev_enable_in});
    rd(REG_GLOBAL, g_exp);
    rd(REG_LANE_A, l_exp);
  endtask : chk_all

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] gv [4] = '{16'hffff, 16'h1554, 16'h0aa2, 16'h0000};
  logic [15:0] lv [4] = '{16'hffff, 16'h0155, 16'h00aa, 16'h0000};

  initial begin
    clk_in = 1'b0;
    resetn_in = 1'b0;
    clk_en_in = 1'b1;
    dev_enable_in = 1'b1;
    phy_addr_in = PHY;
    err_count = 0;
    checks_done = 0;
    g_exp = 16'h0102;
    l_exp = 16'h0132;
    c_exp = 16'h0000;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    chk_all();
    rd(REG_CTRL, 16'h2140);
    foreach (gv[i]) begin
      wr(REG_GLOBAL, gv[i]);
      g_exp = gv[i] & 16'h1ff6;
      chk_all();
    end
    foreach (lv[i]) begin
      wr(REG_LANE_A, lv[i]);
      l_exp = lv[i] & 16'h01ff;
      chk_all();
    end
    wr(REG_CTRL, 16'hffff);
    c_exp = 16'h4800;
    chk_all();
    rd(REG_CTRL, 16'h6940);
    wr(REG_CTRL, 16'h0000);
    c_exp = 16'h0000;
    wr(REG_GLOBAL, 16'h0006);
    g_exp = 16'h0006;
    @(posedge clk_in);
    dev_enable_in <= 1'b0;
    chk_all();
    @(posedge clk_in);
    dev_enable_in <= 1'b1;
    // refused frames: foreign address, unknown opcodes, frozen clock
    @(posedge clk_in);
    mgr.frame(OP_WRITE, 5'h06, REG_GLOBAL, 16'hffff, r, t);
    @(posedge clk_in);
    mgr.frame(OP_READ, 5'h06, REG_GLOBAL, 16'h0000, r, t);
    check(r, 16'hffff);
    for (int op = 0; op < 4; op += 3) begin
      @(posedge clk_in);
      mgr.frame(op[1:0], PHY, REG_GLOBAL, 16'hffff, r, t);
    end
    @(posedge clk_in);
    clk_en_in <= 1'b0;
    wr(REG_LANE_A, 16'h01ff);
    @(posedge clk_in);
    clk_en_in <= 1'b1;
    chk_all();
    rd(5'h12, 16'h0000);
    // second reset in mid-run brings back the defaults
    wr(REG_GLOBAL, 16'h1400);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    g_exp = 16'h0102;
    l_exp = 16'h0132;
    chk_all();
    complete_run();
  end

  // about 46 frames of up to 1300 clocks each; generous margin beyond that
  initial begin
    #480000;
    err_count++;
    complete_run();
  end
endmodule : sbgl_top_tb
`default_nettype wire
